// file: bench/charger_setpoint_registers_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module charger_setpoint_registers_test;
	import charger_setpoint_pkg::*;

	logic                clock;
	logic                rst_n;
	logic [ADDR_W-1:0]   regAddr;
	logic [DATA_W-1:0]   regWrData;
	logic                regWrEn;
	logic                regRdEn;
	logic [DATA_W-1:0]   regRdData;
	logic                regRdValid;
	logic                softResetReq;
	logic                softResetDone;
	logic [BATT_W-1:0]   batteryTargetCode;
	logic [BOOST_W-1:0]  boostOutputCode;
	logic [THERM_W-1:0]  thermalThrottleCode;
	logic [FLOOR_W-1:0]  inputFloorCode;
	logic                inputFloorLoopOn;
	logic [CURR_W-1:0]   chargeCurrentCode;
	logic [TOPOFF_W-1:0] topoffTimeCode;
	logic [PREC_W-1:0]   prechargeVoltageCode;
	logic [PREC_W-1:0]   prechargeCurrentCode;
	logic [7:0]          expReg [5];
	logic [7:0]          a;
	logic [7:0]          d;
	int                  miscompares;
	int                  testsRun;
	localparam logic [7:0] RST_BYTES [5] = '{8'h3c, 8'h67, 8'h0b, 8'h4c, 8'ha1};
	localparam logic [15:0] CORNERS [14] = '{16'h04ff, 16'h04a2, 16'h04a0, 16'h05e3,
		16'h05dc, 16'h05fd, 16'h05e2, 16'h06be, 16'h06c1, 16'h07c8, 16'h07c5,
		16'h07fe, 16'h08dc, 16'h0dff};

	charger_setpoint_registers charger_setpoint_registers_inst (
		.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
		.regRdValid(regRdValid), .softResetReq(softResetReq),
		.softResetDone(softResetDone), .batteryTargetCode(batteryTargetCode),
		.boostOutputCode(boostOutputCode), .thermalThrottleCode(thermalThrottleCode),
		.inputFloorCode(inputFloorCode), .inputFloorLoopOn(inputFloorLoopOn),
		.chargeCurrentCode(chargeCurrentCode), .topoffTimeCode(topoffTimeCode),
		.prechargeVoltageCode(prechargeVoltageCode),
		.prechargeCurrentCode(prechargeCurrentCode)
	);

	host_model host_model_inst (
		.clock(clock), .softResetDone(softResetDone), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.softResetReq(softResetReq)
	);

	function automatic logic [6:0] capped(input logic [6:0] v, input logic [6:0] cap);
		return (v > cap) ? cap : v;
	endfunction

	function automatic logic [7:0] expRead(input logic [7:0] addr);
		return (addr >= 8'h04 && addr <= 8'h08) ? expReg[addr - 8'h04] : 8'h00;
	endfunction

	task automatic checkOutputs();
		`CHK("batteryTargetCode", capped(expReg[0][7:1], 7'h51), batteryTargetCode)
		`CHK("boostOutputCode", capped({1'b0, expReg[1][7:2]}, 7'h38), boostOutputCode)
		`CHK("thermalThrottleCode", expReg[1][1:0], thermalThrottleCode)
		`CHK("inputFloorCode", capped(expReg[2][7:1], 7'h5f), inputFloorCode)
		`CHK("inputFloorLoopOn", expReg[2][0], inputFloorLoopOn)
		`CHK("chargeCurrentCode", capped({1'b0, expReg[3][7:2]}, 7'h32), chargeCurrentCode)
		`CHK("topoffTimeCode", expReg[3][1:0], topoffTimeCode)
		`CHK("prechargeVoltageCode", expReg[4][7:4], prechargeVoltageCode)
		`CHK("prechargeCurrentCode", expReg[4][3:0], prechargeCurrentCode)
	endtask

	// Write, let the taken edge land, then compare every setpoint output
	task automatic writeCheck(input logic [7:0] addr, input logic [7:0] data);
		host_model_inst.access(1'b1, 1'b0, 1'b0, addr, data);
		host_model_inst.access(1'b0, 1'b0, 1'b0, addr, data);
		#1;
		if (addr >= 8'h04 && addr <= 8'h08) begin
			expReg[addr - 8'h04] = (addr == 8'h04) ? {data[7:1], 1'b0} : data;
		end
		checkOutputs();
	endtask

	task automatic readCheck(input logic [7:0] addr);
		host_model_inst.access(1'b0, 1'b1, 1'b0, addr, 8'h00);
		host_model_inst.access(1'b0, 1'b0, 1'b0, addr, 8'h00);
		#1;
		`CHK("regRdValid", 1'b1, regRdValid)
		`CHK("regRdData", expRead(addr), regRdData)
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", testsRun, miscompares);
		if (miscompares == 0 && testsRun > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// Whole run is about 1300 cycles; this is about fifteen times that
	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		print_verdict();
	end

	initial begin
		rst_n = 1'b0;
		miscompares = 0;
		testsRun = 0;
		void'($urandom(32'hc1777a04));
		for (int i = 0; i < 5; i++) begin
			expReg[i] = RST_BYTES[i];
		end
		@(posedge clock);
		#1;
		checkOutputs();
		`CHK("regRdValid in reset", 1'b0, regRdValid)
		repeat (7) @(posedge clock);
		rst_n <= 1'b1;
		for (int i = 3; i <= 9; i++) begin
			readCheck(8'(i));
		end
		// Ceiling boundaries, every thermal throttle code, reserved bit and an unmapped write
		foreach (CORNERS[i]) begin
			writeCheck(CORNERS[i][15:8], CORNERS[i][7:0]);
			readCheck(CORNERS[i][15:8]);
		end
		// Back-to-back writes, then a read colliding with a write
		host_model_inst.access(1'b1, 1'b0, 1'b0, 8'h04, 8'h55);
		expReg[0] = 8'h54;
		writeCheck(8'h07, 8'h31);
		checkOutputs();
		host_model_inst.access(1'b1, 1'b1, 1'b0, 8'h08, 8'h3c);
		host_model_inst.access(1'b0, 1'b0, 1'b0, 8'h08, 8'h00);
		#1;
		`CHK("read before write", 8'hdc, regRdData)
		expReg[4] = 8'h3c;
		checkOutputs();
		for (int n = 0; n < 300; n++) begin
			a = 8'($urandom_range(9, 3));
			d = 8'($urandom);
			writeCheck(a, d);
			readCheck(a);
		end
		// Global reset wins over a write in the same cycle
		host_model_inst.access(1'b1, 1'b0, 1'b1, 8'h07, 8'h00);
		host_model_inst.access(1'b0, 1'b0, 1'b0, 8'h07, 8'h00);
		#1;
		`CHK("softResetDone", 1'b1, softResetDone)
		for (int i = 0; i < 5; i++) begin
			expReg[i] = RST_BYTES[i];
		end
		checkOutputs();
		host_model_inst.access(1'b0, 1'b0, 1'b0, 8'h07, 8'h00);
		#1;
		`CHK("softResetDone pulse", 1'b0, softResetDone)
		for (int i = 4; i <= 8; i++) begin
			readCheck(8'(i));
		end
		print_verdict();
	end
endmodule
`default_nettype wire

// file: bench/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model (
	input  wire logic                                    clock,
	input  wire logic                                    softResetDone,
	output logic      [charger_setpoint_pkg::ADDR_W-1:0] regAddr,
	output logic      [charger_setpoint_pkg::DATA_W-1:0] regWrData,
	output logic                                         regWrEn,
	output logic                                         regRdEn,
	output logic                                         softResetReq
);
	import charger_setpoint_pkg::*;

	logic ocpRaiseAdvised;

	initial begin
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		softResetReq = 1'b0;
		ocpRaiseAdvised = 1'b0;
	end

	// One request per call; released lines toggle so stale values never look valid
	task automatic access(input logic we, input logic re, input logic sr,
		input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
		@(posedge clock);
		regWrEn <= we;
		regRdEn <= re;
		regAddr <= (we || re) ? addr : ~regAddr;
		regWrData <= we ? data : ~regWrData;
		if (sr) begin
			softResetReq <= 1'b1;
		end
		// Above 2.5A the host would also raise the overcurrent level elsewhere
		if (we && addr == OFF_CURR && data[7:2] > 6'd24) begin
			ocpRaiseAdvised <= 1'b1;
		end
	endtask

	// Owner of the global reset bit clears it once the bank acknowledges
	always @(posedge clock) begin
		if (softResetDone) begin
			softResetReq <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: rtl/bank_if.sv
`timescale 1ns/1ns
`default_nettype none
interface bank_if;
	import charger_setpoint_pkg::*;
	logic [NUM_REGS-1:0] match;
	logic [NUM_REGS-1:0] wrSel;
	logic [BATT_W-1:0]   battNxt;
	logic [BOOST_W-1:0]  boostNxt;
	logic [FLOOR_W-1:0]  floorNxt;
	logic [CURR_W-1:0]   currNxt;
	logic [BATT_W-1:0]   battSat;
	logic [BOOST_W-1:0]  boostSat;
	logic [FLOOR_W-1:0]  floorSat;
	logic [CURR_W-1:0]   currSat;

	modport decode (output match, wrSel);
	modport clamp (input battNxt, boostNxt, floorNxt, currNxt,
		output battSat, boostSat, floorSat, currSat);
	modport bank (input match, wrSel, battSat, boostSat, floorSat, currSat,
		output battNxt, boostNxt, floorNxt, currNxt);
endinterface
`default_nettype wire

// file: rtl/charger_setpoint_pkg.sv
package charger_setpoint_pkg;
	localparam int DATA_W   = 8;
	localparam int ADDR_W   = 8;
	localparam int NUM_REGS = 5;

	localparam logic [ADDR_W-1:0] OFF_BATT  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_BOOST = 8'h05;
	localparam logic [ADDR_W-1:0] OFF_FLOOR = 8'h06;
	localparam logic [ADDR_W-1:0] OFF_CURR  = 8'h07;
	localparam logic [ADDR_W-1:0] OFF_PREC  = 8'h08;

	localparam int IDX_BATT  = 0;
	localparam int IDX_BOOST = 1;
	localparam int IDX_FLOOR = 2;
	localparam int IDX_CURR  = 3;
	localparam int IDX_PREC  = 4;

	localparam logic [DATA_W-1:0] RST_BATT_REG  = 8'h3c;
	localparam logic [DATA_W-1:0] RST_BOOST_REG = 8'h67;
	localparam logic [DATA_W-1:0] RST_FLOOR_REG = 8'h0b;
	localparam logic [DATA_W-1:0] RST_CURR_REG  = 8'h4c;
	localparam logic [DATA_W-1:0] RST_PREC_REG  = 8'ha1;

	localparam int BATT_W   = 7;
	localparam int BOOST_W  = 6;
	localparam int THERM_W  = 2;
	localparam int FLOOR_W  = 7;
	localparam int CURR_W   = 6;
	localparam int TOPOFF_W = 2;
	localparam int PREC_W   = 4;
	localparam int SAT_W    = 7;

	localparam int BATT_LSB   = 1;
	localparam int RSVD_POS   = 0;
	localparam int BOOST_LSB  = 2;
	localparam int THERM_LSB  = 0;
	localparam int FLOOR_LSB  = 1;
	localparam int LOOP_POS   = 0;
	localparam int CURR_LSB   = 2;
	localparam int TOPOFF_LSB = 0;
	localparam int PVOLT_LSB  = 4;
	localparam int PCURR_LSB  = 0;

	localparam logic RSVD_BIT = 1'b0;

	localparam logic [BATT_W-1:0]   BATT_RST   = RST_BATT_REG[BATT_LSB +: BATT_W];
	localparam logic [BOOST_W-1:0]  BOOST_RST  = RST_BOOST_REG[BOOST_LSB +: BOOST_W];
	localparam logic [THERM_W-1:0]  THERM_RST  = RST_BOOST_REG[THERM_LSB +: THERM_W];
	localparam logic [FLOOR_W-1:0]  FLOOR_RST  = RST_FLOOR_REG[FLOOR_LSB +: FLOOR_W];
	localparam logic                LOOP_RST   = RST_FLOOR_REG[LOOP_POS];
	localparam logic [CURR_W-1:0]   CURR_RST   = RST_CURR_REG[CURR_LSB +: CURR_W];
	localparam logic [TOPOFF_W-1:0] TOPOFF_RST = RST_CURR_REG[TOPOFF_LSB +: TOPOFF_W];
	localparam logic [PREC_W-1:0]   PVOLT_RST  = RST_PREC_REG[PVOLT_LSB +: PREC_W];
	localparam logic [PREC_W-1:0]   PCURR_RST  = RST_PREC_REG[PCURR_LSB +: PREC_W];

	// Codes past these all select the top setpoint of their loop
	localparam logic [BATT_W-1:0]  BATT_MAX  = 7'h51;
	localparam logic [BOOST_W-1:0] BOOST_MAX = 6'h38;
	localparam logic [FLOOR_W-1:0] FLOOR_MAX = 7'h5f;
	localparam logic [CURR_W-1:0]  CURR_MAX  = 6'h32;
endpackage

// file: rtl/charger_setpoint_registers.sv
`timescale 1ns/1ns
`default_nettype none
module charger_setpoint_registers (
	input  wire logic                                      clock,
	input  wire logic                                      rst_n,
	input  wire logic [charger_setpoint_pkg::ADDR_W-1:0]   regAddr,
	input  wire logic [charger_setpoint_pkg::DATA_W-1:0]   regWrData,
	input  wire logic                                      regWrEn,
	input  wire logic                                      regRdEn,
	output logic      [charger_setpoint_pkg::DATA_W-1:0]   regRdData,
	output logic                                           regRdValid,
	input  wire logic                                      softResetReq,
	output logic                                           softResetDone,
	output logic      [charger_setpoint_pkg::BATT_W-1:0]   batteryTargetCode,
	output logic      [charger_setpoint_pkg::BOOST_W-1:0]  boostOutputCode,
	output logic      [charger_setpoint_pkg::THERM_W-1:0]  thermalThrottleCode,
	output logic      [charger_setpoint_pkg::FLOOR_W-1:0]  inputFloorCode,
	output logic                                           inputFloorLoopOn,
	output logic      [charger_setpoint_pkg::CURR_W-1:0]   chargeCurrentCode,
	output logic      [charger_setpoint_pkg::TOPOFF_W-1:0] topoffTimeCode,
	output logic      [charger_setpoint_pkg::PREC_W-1:0]   prechargeVoltageCode,
	output logic      [charger_setpoint_pkg::PREC_W-1:0]   prechargeCurrentCode
);
	import charger_setpoint_pkg::*;

	bank_if bus ();

	logic [BATT_W-1:0]   battRaw_r;
	logic [BOOST_W-1:0]  boostRaw_r;
	logic [THERM_W-1:0]  therm_r;
	logic [FLOOR_W-1:0]  floorRaw_r;
	logic                loopOn_r;
	logic [CURR_W-1:0]   currRaw_r;
	logic [TOPOFF_W-1:0] topoff_r;
	logic [PREC_W-1:0]   pvolt_r;
	logic [PREC_W-1:0]   pcurr_r;
	logic [BATT_W-1:0]   battSat_r;
	logic [BOOST_W-1:0]  boostSat_r;
	logic [FLOOR_W-1:0]  floorSat_r;
	logic [CURR_W-1:0]   currSat_r;
	logic [DATA_W-1:0]   rdData_r;
	logic                rdValid_r;
	logic                softDone_r;

	logic [BATT_W-1:0]   wrBattField;
	logic [BOOST_W-1:0]  wrBoostField;
	logic [THERM_W-1:0]  wrThermField;
	logic [FLOOR_W-1:0]  wrFloorField;
	logic                wrLoopField;
	logic [CURR_W-1:0]   wrCurrField;
	logic [TOPOFF_W-1:0] wrTopoffField;
	logic [PREC_W-1:0]   wrPvoltField;
	logic [PREC_W-1:0]   wrPcurrField;
	logic [THERM_W-1:0]  thermNxt;
	logic                loopNxt;
	logic [TOPOFF_W-1:0] topoffNxt;
	logic [PREC_W-1:0]   pvoltNxt;
	logic [PREC_W-1:0]   pcurrNxt;
	logic [DATA_W-1:0]   battByte;
	logic [DATA_W-1:0]   boostByte;
	logic [DATA_W-1:0]   floorByte;
	logic [DATA_W-1:0]   currByte;
	logic [DATA_W-1:0]   precByte;
	logic [DATA_W-1:0]   rdMux;
	logic                wrBatt;
	logic                wrBoost;
	logic                wrFloor;
	logic                wrCurr;
	logic                wrPrec;

	reg_addr_decode decoder (
		.regAddr (regAddr),
		.regWrEn (regWrEn),
		.bus     (bus)
	);

	setpoint_clamp clamp (
		.bus (bus)
	);

	assign wrBatt  = bus.wrSel[IDX_BATT];
	assign wrBoost = bus.wrSel[IDX_BOOST];
	assign wrFloor = bus.wrSel[IDX_FLOOR];
	assign wrCurr  = bus.wrSel[IDX_CURR];
	assign wrPrec  = bus.wrSel[IDX_PREC];

	// The reserved bit position is not sliced into the battery field, so writes to it vanish
	assign wrBattField   = regWrData[BATT_LSB +: BATT_W];
	assign wrBoostField  = regWrData[BOOST_LSB +: BOOST_W];
	assign wrThermField  = regWrData[THERM_LSB +: THERM_W];
	assign wrFloorField  = regWrData[FLOOR_LSB +: FLOOR_W];
	assign wrLoopField   = regWrData[LOOP_POS];
	assign wrCurrField   = regWrData[CURR_LSB +: CURR_W];
	assign wrTopoffField = regWrData[TOPOFF_LSB +: TOPOFF_W];
	assign wrPvoltField  = regWrData[PVOLT_LSB +: PREC_W];
	assign wrPcurrField  = regWrData[PCURR_LSB +: PREC_W];

	// A global reset request outranks a host write landing in the same cycle
	assign bus.battNxt  = softResetReq ? BATT_RST : (wrBatt ? wrBattField : battRaw_r);
	assign bus.boostNxt = softResetReq ? BOOST_RST : (wrBoost ? wrBoostField : boostRaw_r);
	assign thermNxt     = softResetReq ? THERM_RST : (wrBoost ? wrThermField : therm_r);
	assign bus.floorNxt = softResetReq ? FLOOR_RST : (wrFloor ? wrFloorField : floorRaw_r);
	assign loopNxt      = softResetReq ? LOOP_RST : (wrFloor ? wrLoopField : loopOn_r);
	assign bus.currNxt  = softResetReq ? CURR_RST : (wrCurr ? wrCurrField : currRaw_r);
	assign topoffNxt    = softResetReq ? TOPOFF_RST : (wrCurr ? wrTopoffField : topoff_r);
	assign pvoltNxt     = softResetReq ? PVOLT_RST : (wrPrec ? wrPvoltField : pvolt_r);
	assign pcurrNxt     = softResetReq ? PCURR_RST : (wrPrec ? wrPcurrField : pcurr_r);

	// Raw codes are kept for readback; the loops get the clamped copies
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			battRaw_r  <= BATT_RST;
			boostRaw_r <= BOOST_RST;
			floorRaw_r <= FLOOR_RST;
			currRaw_r  <= CURR_RST;
		end else begin
			battRaw_r  <= bus.battNxt;
			boostRaw_r <= bus.boostNxt;
			floorRaw_r <= bus.floorNxt;
			currRaw_r  <= bus.currNxt;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			battSat_r  <= BATT_RST;
			boostSat_r <= BOOST_RST;
			floorSat_r <= FLOOR_RST;
			currSat_r  <= CURR_RST;
		end else begin
			battSat_r  <= bus.battSat;
			boostSat_r <= bus.boostSat;
			floorSat_r <= bus.floorSat;
			currSat_r  <= bus.currSat;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			therm_r  <= THERM_RST;
			loopOn_r <= LOOP_RST;
			topoff_r <= TOPOFF_RST;
			pvolt_r  <= PVOLT_RST;
			pcurr_r  <= PCURR_RST;
		end else begin
			therm_r  <= thermNxt;
			loopOn_r <= loopNxt;
			topoff_r <= topoffNxt;
			pvolt_r  <= pvoltNxt;
			pcurr_r  <= pcurrNxt;
		end
	end

	// Done pulses on alternate cycles while the request is held; the owner of the request bit clears it on this
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			softDone_r <= 1'b0;
		end else begin
			softDone_r <= softResetReq & ~softDone_r;
		end
	end

	assign battByte  = {battRaw_r, RSVD_BIT};
	assign boostByte = {boostRaw_r, therm_r};
	assign floorByte = {floorRaw_r, loopOn_r};
	assign currByte  = {currRaw_r, topoff_r};
	assign precByte  = {pvolt_r, pcurr_r};

	// Unmapped addresses select nothing and read as zero
	assign rdMux = ({DATA_W{bus.match[IDX_BATT]}} & battByte)
		| ({DATA_W{bus.match[IDX_BOOST]}} & boostByte)
		| ({DATA_W{bus.match[IDX_FLOOR]}} & floorByte)
		| ({DATA_W{bus.match[IDX_CURR]}} & currByte)
		| ({DATA_W{bus.match[IDX_PREC]}} & precByte);

	// A read in the same cycle as a write returns the value before the write
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdData_r  <= '0;
			rdValid_r <= 1'b0;
		end else begin
			rdData_r  <= regRdEn ? rdMux : rdData_r;
			rdValid_r <= regRdEn;
		end
	end

	assign regRdData            = rdData_r;
	assign regRdValid           = rdValid_r;
	assign softResetDone        = softDone_r;
	assign batteryTargetCode    = battSat_r;
	assign boostOutputCode      = boostSat_r;
	assign thermalThrottleCode  = therm_r;
	assign inputFloorCode       = floorSat_r;
	assign inputFloorLoopOn     = loopOn_r;
	assign chargeCurrentCode    = currSat_r;
	assign topoffTimeCode       = topoff_r;
	assign prechargeVoltageCode = pvolt_r;
	assign prechargeCurrentCode = pcurr_r;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	reset_values_a: assert property (
		$rose(rst_n) |-> batteryTargetCode == BATT_RST && boostOutputCode == BOOST_RST
			&& thermalThrottleCode == THERM_RST && inputFloorCode == FLOOR_RST
			&& inputFloorLoopOn == LOOP_RST && chargeCurrentCode == CURR_RST
			&& topoffTimeCode == TOPOFF_RST && prechargeVoltageCode == PVOLT_RST
			&& prechargeCurrentCode == PCURR_RST)
		else $error("setpoints not at reset values after reset");

	soft_reset_a: assert property (
		softResetReq |=> batteryTargetCode == BATT_RST && chargeCurrentCode == CURR_RST
			&& inputFloorLoopOn == LOOP_RST && prechargeCurrentCode == PCURR_RST
			&& thermalThrottleCode == THERM_RST && !$stable(softResetDone))
		else $error("global reset did not reload bank or toggle done");

	done_pulse_a: assert property (
		softResetDone |-> $past(softResetReq) ##1 !softResetDone)
		else $error("reset done is not a single pulse after a request");

	batt_ceiling_a: assert property (
		batteryTargetCode == ((battRaw_r > BATT_MAX) ? BATT_MAX : battRaw_r))
		else $error("battery target not saturated at ceiling");

	boost_ceiling_a: assert property (
		(boostRaw_r >= BOOST_MAX) |-> boostOutputCode == BOOST_MAX)
		else $error("boost code not saturated at ceiling");

	floor_ceiling_a: assert property (
		inputFloorCode == ((floorRaw_r > FLOOR_MAX) ? FLOOR_MAX : floorRaw_r))
		else $error("input floor code not saturated at ceiling");

	curr_ceiling_a: assert property (
		(currRaw_r < CURR_MAX) |-> chargeCurrentCode == currRaw_r)
		else $error("charge current below ceiling altered");

	curr_write_a: assert property (
		regWrEn && regAddr == OFF_CURR && !softResetReq
			|=> currRaw_r == $past(wrCurrField)
			&& topoffTimeCode == $past(wrTopoffField))
		else $error("charge current write not applied on its edge");

	curr_hold_a: assert property (
		!wrCurr && !softResetReq |=> $stable(chargeCurrentCode) && $stable(topoffTimeCode))
		else $error("charge current changed without a write");

	thermal_write_a: assert property (
		wrBoost && !softResetReq |=> thermalThrottleCode == $past(wrThermField))
		else $error("thermal throttle write not applied");

	loop_on_a: assert property (
		wrFloor && !softResetReq |=> inputFloorLoopOn == $past(wrLoopField))
		else $error("input floor loop enable write not applied");

	reserved_zero_a: assert property (
		regRdEn && regAddr == OFF_BATT |=> regRdValid && regRdData[RSVD_POS] == RSVD_BIT
			&& regRdData[BATT_LSB +: BATT_W] == $past(battRaw_r))
		else $error("battery register readback wrong or reserved bit set");

	unmapped_read_a: assert property (
		regRdEn && bus.match == '0 |=> regRdValid && regRdData == '0)
		else $error("unmapped read did not return zero");

	batt_write_a: assert property (
		wrBatt && !softResetReq |=> battRaw_r == $past(wrBattField))
		else $error("battery target write not applied");

	boost_pass_a: assert property (
		(boostRaw_r < BOOST_MAX) |-> boostOutputCode == boostRaw_r)
		else $error("boost code below ceiling altered");

	floor_write_a: assert property (
		wrFloor && !softResetReq |=> floorRaw_r == $past(wrFloorField))
		else $error("input floor write not applied");

	prec_write_a: assert property (
		wrPrec && !softResetReq |=> prechargeVoltageCode == $past(wrPvoltField)
			&& prechargeCurrentCode == $past(wrPcurrField))
		else $error("precharge write not applied");

	read_pulse_a: assert property (
		!regRdEn |=> !regRdValid)
		else $error("read valid raised without a read");

	read_hold_a: assert property (
		!regRdEn |=> $stable(regRdData))
		else $error("read data changed without a read");
endmodule
`default_nettype wire

// file: rtl/reg_addr_decode.sv
`timescale 1ns/1ns
`default_nettype none
module reg_addr_decode (
	input  wire logic [charger_setpoint_pkg::ADDR_W-1:0] regAddr,
	input  wire logic                                    regWrEn,
	bank_if.decode                                       bus
);
	import charger_setpoint_pkg::*;

	function automatic logic [NUM_REGS-1:0] decodeAddr(input logic [ADDR_W-1:0] addr);
		logic [NUM_REGS-1:0] sel;
		sel = '0;
		case (addr)
			OFF_BATT:  sel[IDX_BATT] = 1'b1;
			OFF_BOOST: sel[IDX_BOOST] = 1'b1;
			OFF_FLOOR: sel[IDX_FLOOR] = 1'b1;
			OFF_CURR:  sel[IDX_CURR] = 1'b1;
			OFF_PREC:  sel[IDX_PREC] = 1'b1;
			default:   sel = '0;
		endcase
		return sel;
	endfunction

	// Unmapped addresses match nothing, so writes there are dropped
	assign bus.match = decodeAddr(regAddr);
	assign bus.wrSel = bus.match & {NUM_REGS{regWrEn}};
endmodule
`default_nettype wire

// file: rtl/setpoint_clamp.sv
`timescale 1ns/1ns
`default_nettype none
module setpoint_clamp (
	bank_if.clamp bus
);
	import charger_setpoint_pkg::*;

	function automatic logic [SAT_W-1:0] saturate(input logic [SAT_W-1:0] code,
		input logic [SAT_W-1:0] ceiling);
		return (code > ceiling) ? ceiling : code;
	endfunction

	// Clamping sits on the next-value path so the loops see it on the write edge
	assign bus.battSat  = BATT_W'(saturate(SAT_W'(bus.battNxt), SAT_W'(BATT_MAX)));
	assign bus.boostSat = BOOST_W'(saturate(SAT_W'(bus.boostNxt), SAT_W'(BOOST_MAX)));
	assign bus.floorSat = FLOOR_W'(saturate(SAT_W'(bus.floorNxt), SAT_W'(FLOOR_MAX)));
	assign bus.currSat  = CURR_W'(saturate(SAT_W'(bus.currNxt), SAT_W'(CURR_MAX)));
endmodule
`default_nettype wire
